/* rtl/pmc_power_mode_control.sv */
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// (R1) Idle select waits instruction end, stops CPU
// (R2) Idle keeps state; peripherals stay clocked
// (R3) Only enabled interrupt or reset ends idle
// (R4) Interrupt wake clears idle, resumes CPU
// (R5) After return, execution continues after setter
// (R6) Reset ending idle restarts at 0x0000
// (R7) Watchdog keeps counting in idle; expiry resets
// (R8) Stop select halts CPU, oscillators, clock
// (R9) Only reset ends stop; restart at 0x0000
// (R10) Lost clock detector resets stop after 100us
// (R11) Software disables detector for long stops
// (R12) Software powers down analog before stop
// (R13) Idle and stop select read zero
// (R14) Bit 7 doubles serial port rate
// (R15) Bits 6 to 4 read zero, ignore writes
// (R16) Bits 3 and 2 are plain user flags
// (R17) Wake uses pending-and-enabled, not priority
module pmc_power_mode_control #(
    parameter int LOST_CLK_CYCLES = pmc_pkg::PMC_LOST_CLK_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  sfr_wdata,
    output logic      [7:0]  sfr_rdata_q,
    input  wire logic        instr_done,
    input  wire logic        irq_pending_enabled,
    input  wire logic        ext_reset_pin_n,
    input  wire logic        watchdog_timer_expired,
    input  wire logic        lost_clock_detector_en,
    output logic             cpu_clk_en_q,
    output logic             periph_clk_en_q,
    output logic             osc_en_q,
    output logic             watchdog_timer_clk_en_q,
    output logic             core_reset_q,
    output logic      [15:0] reset_vector_q,
    output logic             idle_wake_q,
    output logic             baud_doubler_q,
    output logic             user_flag_1_q,
    output logic             user_flag_0_q
);
    pmc_pkg::pmc_state_t state_q;
    pmc_pkg::pmc_state_t state_d;

    logic       pin_meta_q;
    logic       pin_sync_n_q;
    logic       idle_sel_q;
    logic       stop_sel_q;
    logic [2:0] seq_cnt_q;
    logic       lost_clk_expired;
    logic       ctrl_wr;
    logic       ctrl_rd;
    logic       reset_evt;

    // Register decode
    assign ctrl_wr = sfr_wr && (sfr_addr == pmc_pkg::PMC_POWER_MODE_CONTROL_ADDR);
    assign ctrl_rd = sfr_rd && (sfr_addr == pmc_pkg::PMC_POWER_MODE_CONTROL_ADDR);

    // Two-flop synchroniser for the reset pin
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_meta_q   <= 1'b1;
            pin_sync_n_q <= 1'b1;
        end else begin
            pin_meta_q   <= ext_reset_pin_n;
            pin_sync_n_q <= pin_meta_q;
        end
    end

    // Armed only in stop with the detector enabled
    pmc_lost_clock_timer #(
        .CYCLES (LOST_CLK_CYCLES)
    ) pmc_lost_clock_timer_inst (
        .clk       (clk),
        .resetn    (resetn),
        .run       ((state_q == pmc_pkg::PMC_ST_STOP) && lost_clock_detector_en), // R10
        .expired_q (lost_clk_expired)
    );

    // Any reset source that ends a low-power mode
    assign reset_evt = !pin_sync_n_q || watchdog_timer_expired || lost_clk_expired; // R7 R10

    // Storage bits; select bits clear on entry or reset
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            baud_doubler_q <= pmc_pkg::PMC_POWER_MODE_CONTROL_RST[pmc_pkg::PMC_BAUD_DBL_BIT];
            user_flag_1_q  <= pmc_pkg::PMC_POWER_MODE_CONTROL_RST[pmc_pkg::PMC_USER_FLAG1_BIT];
            user_flag_0_q  <= pmc_pkg::PMC_POWER_MODE_CONTROL_RST[pmc_pkg::PMC_USER_FLAG0_BIT];
        end else if (reset_evt) begin
            baud_doubler_q <= 1'b0;
            user_flag_1_q  <= 1'b0;
            user_flag_0_q  <= 1'b0;
        end else if (ctrl_wr) begin
            baud_doubler_q <= sfr_wdata[pmc_pkg::PMC_BAUD_DBL_BIT];   // R14
            user_flag_1_q  <= sfr_wdata[pmc_pkg::PMC_USER_FLAG1_BIT]; // R16
            user_flag_0_q  <= sfr_wdata[pmc_pkg::PMC_USER_FLAG0_BIT]; // R16
        end
    end

    // Self-clearing select bits
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            idle_sel_q <= 1'b0;
            stop_sel_q <= 1'b0;
        end else if (reset_evt || state_q != pmc_pkg::PMC_ST_RUN) begin
            idle_sel_q <= 1'b0; // R4
            stop_sel_q <= 1'b0;
        end else if (ctrl_wr) begin
            idle_sel_q <= sfr_wdata[pmc_pkg::PMC_IDLE_SEL_BIT]; // R1
            stop_sel_q <= sfr_wdata[pmc_pkg::PMC_STOP_SEL_BIT]; // R8
        end
    end

    // Read data: selects and unused bits always zero
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sfr_rdata_q <= 8'h00;
        end else if (ctrl_rd) begin
            sfr_rdata_q <= {baud_doubler_q, 3'h0, user_flag_1_q, user_flag_0_q, 2'h0}; // R13 R15
        end else begin
            sfr_rdata_q <= 8'h00;
        end
    end

    // Mode sequencing
    always_comb begin
        state_d = state_q;
        case (state_q)
            pmc_pkg::PMC_ST_RUN: begin
                if (stop_sel_q) begin
                    state_d = pmc_pkg::PMC_ST_STOP_PEND;
                end else if (idle_sel_q) begin
                    state_d = pmc_pkg::PMC_ST_IDLE_PEND;
                end
            end
            pmc_pkg::PMC_ST_IDLE_PEND: begin
                if (instr_done) begin
                    state_d = pmc_pkg::PMC_ST_IDLE; // R1
                end
            end
            pmc_pkg::PMC_ST_IDLE: begin
                if (irq_pending_enabled) begin
                    state_d = pmc_pkg::PMC_ST_RUN; // R3 R4 R5 R17
                end
            end
            pmc_pkg::PMC_ST_STOP_PEND: begin
                if (instr_done) begin
                    state_d = pmc_pkg::PMC_ST_STOP; // R8
                end
            end
            pmc_pkg::PMC_ST_STOP: begin
                state_d = pmc_pkg::PMC_ST_STOP; // R9
            end
            pmc_pkg::PMC_ST_RESET_SEQ: begin
                if (seq_cnt_q == 3'(pmc_pkg::PMC_RESET_SEQ_CYCLES - 1)) begin
                    state_d = pmc_pkg::PMC_ST_RUN;
                end
            end
            default: begin
                state_d = pmc_pkg::PMC_ST_RESET_SEQ;
            end
        endcase
        if (reset_evt) begin
            state_d = pmc_pkg::PMC_ST_RESET_SEQ; // R6 R9
        end
    end

    // State and reset sequence length
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= pmc_pkg::PMC_ST_RESET_SEQ;
            seq_cnt_q <= 3'h0;
        end else begin
            state_q   <= state_d;
            seq_cnt_q <= (state_d == pmc_pkg::PMC_ST_RESET_SEQ && state_q == state_d)
                         ? seq_cnt_q + 3'h1 : 3'h0;
        end
    end

    // Clock enables and core controls follow the next state
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cpu_clk_en_q            <= 1'b0;
            periph_clk_en_q         <= 1'b1;
            osc_en_q                <= 1'b1;
            watchdog_timer_clk_en_q <= 1'b1;
            core_reset_q            <= 1'b1;
            reset_vector_q          <= pmc_pkg::PMC_RESET_VECTOR;
            idle_wake_q             <= 1'b0;
        end else begin
            cpu_clk_en_q            <= (state_d == pmc_pkg::PMC_ST_RUN)
                                    || (state_d == pmc_pkg::PMC_ST_IDLE_PEND)
                                    || (state_d == pmc_pkg::PMC_ST_STOP_PEND)
                                    || (state_d == pmc_pkg::PMC_ST_RESET_SEQ);
            periph_clk_en_q         <= (state_d != pmc_pkg::PMC_ST_STOP); // R2 R8
            osc_en_q                <= (state_d != pmc_pkg::PMC_ST_STOP); // R8
            watchdog_timer_clk_en_q <= (state_d != pmc_pkg::PMC_ST_STOP); // R7
            core_reset_q            <= (state_d == pmc_pkg::PMC_ST_RESET_SEQ); // R6
            reset_vector_q          <= pmc_pkg::PMC_RESET_VECTOR; // R6 R9
            idle_wake_q             <= (state_q == pmc_pkg::PMC_ST_IDLE)
                                    && (state_d == pmc_pkg::PMC_ST_RUN); // R4
        end
    end

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    idle_entry_a: assert property ((state_q == pmc_pkg::PMC_ST_IDLE_PEND) && instr_done // R1
        && !reset_evt |=> (state_q == pmc_pkg::PMC_ST_IDLE) && !cpu_clk_en_q)
        else $error("idle not entered after instruction end");
    idle_periph_a: assert property ((state_q == pmc_pkg::PMC_ST_IDLE) // R2
        |-> periph_clk_en_q && osc_en_q)
        else $error("peripheral clock lost in idle");
    idle_hold_a: assert property ((state_q == pmc_pkg::PMC_ST_IDLE) && !irq_pending_enabled // R3
        && !reset_evt |=> (state_q == pmc_pkg::PMC_ST_IDLE))
        else $error("idle left without cause");
    idle_wake_a: assert property ((state_q == pmc_pkg::PMC_ST_IDLE) && irq_pending_enabled // R4
        && !reset_evt |=> idle_wake_q && cpu_clk_en_q && !core_reset_q ##1 !idle_wake_q)
        else $error("interrupt wake incorrect");
    reset_seq_a: assert property (reset_evt |=> core_reset_q && cpu_clk_en_q // R6
        && (reset_vector_q == pmc_pkg::PMC_RESET_VECTOR))
        else $error("reset sequence not started");
    watchdog_idle_a: assert property ((state_q == pmc_pkg::PMC_ST_IDLE) // R7
        |-> watchdog_timer_clk_en_q)
        else $error("watchdog stopped in idle");
    stop_entry_a: assert property ((state_q == pmc_pkg::PMC_ST_STOP_PEND) && instr_done // R8
        && !reset_evt |=> !osc_en_q && !cpu_clk_en_q && !periph_clk_en_q)
        else $error("stop not entered");
    stop_hold_a: assert property ((state_q == pmc_pkg::PMC_ST_STOP) && !reset_evt // R9
        |=> (state_q == pmc_pkg::PMC_ST_STOP))
        else $error("stop left without reset");
    lost_clk_a: assert property (lost_clk_expired |=> core_reset_q // R10
        && (state_q == pmc_pkg::PMC_ST_RESET_SEQ))
        else $error("lost clock timeout did not reset");
    read_zero_a: assert property (ctrl_rd |=> (sfr_rdata_q[6:4] == 3'h0) // R13 R15
        && (sfr_rdata_q[1:0] == 2'h0))
        else $error("reserved or select bits read nonzero");
    baud_write_a: assert property (ctrl_wr && !reset_evt |=> // R14 R16
        baud_doubler_q == $past(sfr_wdata[7]) && user_flag_1_q == $past(sfr_wdata[3])
        && user_flag_0_q == $past(sfr_wdata[2]))
        else $error("stored bits not updated");

    idle_wake_c: cover property ((state_q == pmc_pkg::PMC_ST_IDLE) ##1 idle_wake_q);
    stop_reset_c: cover property ((state_q == pmc_pkg::PMC_ST_STOP) ##1 core_reset_q);
    idle_reset_c: cover property ((state_q == pmc_pkg::PMC_ST_IDLE) && watchdog_timer_expired);

endmodule : pmc_power_mode_control
`default_nettype wire

/* rtl/pmc_pkg.sv */
package pmc_pkg;

    // Register location on the special-function bus
    localparam logic [7:0] PMC_POWER_MODE_CONTROL_ADDR = 8'h87;
    localparam logic [7:0] PMC_POWER_MODE_CONTROL_RST  = 8'h00;

    // Field positions in power_mode_control
    localparam int PMC_IDLE_SEL_BIT   = 0;
    localparam int PMC_STOP_SEL_BIT   = 1;
    localparam int PMC_USER_FLAG0_BIT = 2;
    localparam int PMC_USER_FLAG1_BIT = 3;
    localparam int PMC_BAUD_DBL_BIT   = 7;

    // Restart address after any reset sequence
    localparam logic [15:0] PMC_RESET_VECTOR = 16'h0000;

    // Timing: lost clock timeout and the clock period, both in ns
    localparam int PMC_LOST_CLK_TIMEOUT_NS = 100000;
    localparam int PMC_CLK_PERIOD_NS       = 8;
    localparam int PMC_LOST_CLK_CYCLES     = PMC_LOST_CLK_TIMEOUT_NS / PMC_CLK_PERIOD_NS;

    // Length of the core reset pulse in cycles
    localparam int PMC_RESET_SEQ_CYCLES = 4;

    // Mode controller states, one-hot
    typedef enum logic [5:0] {
        PMC_ST_RUN       = 6'h01,
        PMC_ST_IDLE_PEND = 6'h02,
        PMC_ST_IDLE      = 6'h04,
        PMC_ST_STOP_PEND = 6'h08,
        PMC_ST_STOP      = 6'h10,
        PMC_ST_RESET_SEQ = 6'h20
    } pmc_state_t;

endpackage : pmc_pkg

/* rtl/pmc_lost_clock_timer.sv */
`timescale 1ns/10ps
`default_nettype none

module pmc_lost_clock_timer #(
    parameter int CYCLES = pmc_pkg::PMC_LOST_CLK_CYCLES
) (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic run,
    output logic      expired_q
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] count_q;

    // Counts while armed, restarts whenever disarmed
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            count_q   <= '0;
            expired_q <= 1'b0;
        end else if (!run) begin
            count_q   <= '0;
            expired_q <= 1'b0;
        end else if (count_q == LAST) begin
            count_q   <= '0;
            expired_q <= 1'b1;
        end else begin
            count_q   <= count_q + W'(1);
            expired_q <= 1'b0;
        end
    end

endmodule : pmc_lost_clock_timer
`default_nettype wire

/* testbench/pmc_core_model.sv */
`timescale 1ns/10ps
`default_nettype none

module pmc_core_model (
    input  wire logic clk,
    input  wire logic cpu_clk_en_q,
    input  wire logic core_reset_q,
    input  wire logic idle_wake_q,
    input  wire logic irq_cmd,
    input  wire logic dog_cmd,
    input  wire logic pin_cmd,
    output logic      instr_done,
    output logic      irq_pending_enabled,
    output logic      ext_reset_pin_n,
    output logic      watchdog_timer_expired
);
    logic [1:0] phase_q;

    // Quiet partner outputs at time zero
    initial begin
        phase_q = 2'h0;
        instr_done = 1'b0;
        irq_pending_enabled = 1'b0;
        ext_reset_pin_n = 1'b1;
        watchdog_timer_expired = 1'b0;
    end

    // Core ends an instruction every fourth cycle while clocked
    always @(posedge clk) begin
        phase_q <= phase_q + 2'h1;
        instr_done <= cpu_clk_en_q && !core_reset_q && (phase_q == 2'h3);
        watchdog_timer_expired <= dog_cmd;
        ext_reset_pin_n <= !pin_cmd;
    end

    // Pending request held until serviced or reset
    always @(posedge clk) begin
        if (idle_wake_q || core_reset_q) begin
            irq_pending_enabled <= 1'b0;
        end else if (irq_cmd) begin
            irq_pending_enabled <= 1'b1;
        end
    end
endmodule : pmc_core_model

`default_nettype wire

/* testbench/core_power_mode_control_tb.sv */
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
    $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); end end

module core_power_mode_control_tb;
    logic        clk = 1'b0;
    logic        resetn, sfr_wr, sfr_rd, irq_cmd, dog_cmd, pin_cmd, lcd_en;
    logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata_q, v, exp_v;
    logic        instr_done, irq_pe, pin_n, dog_exp, rd_seen = 1'b0;
    logic        cpu_en, per_en, osc_en, dog_en, core_rst, wake, baud, uf1, uf0;
    logic [15:0] vec;
    logic [7:0]  rd_q[$];
    int          n_fail = 0, comparisons = 0, i, k, n;

    always #4 clk = ~clk;

    pmc_power_mode_control #(.LOST_CLK_CYCLES(20)) pmc_power_mode_control_inst (
        .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q),
        .instr_done(instr_done), .irq_pending_enabled(irq_pe),
        .ext_reset_pin_n(pin_n), .watchdog_timer_expired(dog_exp),
        .lost_clock_detector_en(lcd_en), .cpu_clk_en_q(cpu_en),
        .periph_clk_en_q(per_en), .osc_en_q(osc_en), .watchdog_timer_clk_en_q(dog_en),
        .core_reset_q(core_rst), .reset_vector_q(vec), .idle_wake_q(wake),
        .baud_doubler_q(baud), .user_flag_1_q(uf1), .user_flag_0_q(uf0));

    pmc_core_model pmc_core_model_inst (
        .clk(clk), .cpu_clk_en_q(cpu_en), .core_reset_q(core_rst), .idle_wake_q(wake),
        .irq_cmd(irq_cmd), .dog_cmd(dog_cmd), .pin_cmd(pin_cmd),
        .instr_done(instr_done), .irq_pending_enabled(irq_pe),
        .ext_reset_pin_n(pin_n), .watchdog_timer_expired(dog_exp));

    // Read results checked against the oldest noted value
    always @(posedge clk) rd_seen <= sfr_rd;
    always @(negedge clk) begin
        if (rd_seen) begin
            exp_v = rd_q.pop_front();
            `CHK(sfr_rdata_q, exp_v)
        end
    end

    task automatic end_of_test();
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // One register access held over one sampling edge, then one quiet edge
    task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        sfr_wr = wr;
        sfr_rd = !wr;
        sfr_addr = a;
        sfr_wdata = d;
        if (!wr) rd_q.push_back(d);
        @(negedge clk);
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(negedge clk);
    endtask : acc

    // Bounded wait on cpu clock enable or core reset
    task automatic wait_sig(input logic rst, input logic val, output int cnt);
        for (cnt = 0; cnt < 200; cnt++) begin
            @(negedge clk);
            if ((rst ? core_rst : cpu_en) === val) return;
        end
        n_fail++;
        end_of_test();
    endtask : wait_sig

    initial begin
        {resetn, sfr_wr, sfr_rd, irq_cmd, dog_cmd, pin_cmd, lcd_en} = 7'h00;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        void'($urandom(32'hdee4));
        repeat (16) @(negedge clk);
        resetn = 1'b1;
        wait_sig(1'b1, 1'b0, n);
        acc(1'b0, 8'h87, 8'h00);
        // Random stored bits, unused bits must stay zero
        for (i = 0; i < 8; i++) begin
            v = 8'($urandom);
            acc(1'b1, 8'h87, v & 8'hfc);
            acc(1'b0, 8'h87, v & 8'h8c);
            `CHK({baud, uf1, uf0}, {v[7], v[3], v[2]})
        end
        acc(1'b1, 8'h86, 8'hff);
        acc(1'b0, 8'h86, 8'h00);
        acc(1'b0, 8'h87, v & 8'h8c);
        // Idle ended by interrupt, watchdog, then pin
        for (k = 0; k < 3; k++) begin
            acc(1'b1, 8'h87, 8'h8d);
            acc(1'b0, 8'h87, 8'h8c);
            wait_sig(1'b0, 1'b0, n);
            `CHK({per_en, osc_en, dog_en}, 3'b111)
            repeat (10) @(negedge clk);
            `CHK(cpu_en, 1'b0)
            irq_cmd = (k == 0);
            dog_cmd = (k == 1);
            pin_cmd = (k == 2);
            @(negedge clk);
            {irq_cmd, dog_cmd} = 2'b00;
            if (k == 0) begin
                wait_sig(1'b0, 1'b1, n);
                `CHK({wake, core_rst, baud, uf1, uf0}, 5'h17)
            end else begin
                wait_sig(1'b1, 1'b1, n);
                pin_cmd = 1'b0;
                `CHK({vec, baud, uf0}, 18'h0)
                wait_sig(1'b1, 1'b0, n);
            end
        end
        // Stop: interrupts ignored, pin or lost clock resets
        for (k = 0; k < 2; k++) begin
            lcd_en = k[0];
            // Stop alone first, then stop with idle; analog taken as already off
            acc(1'b1, 8'h87, {7'h01, k[0]});
            wait_sig(1'b0, 1'b0, n);
            `CHK({per_en, osc_en, dog_en}, 3'b000)
            if (k == 0) begin
                irq_cmd = 1'b1;
                @(negedge clk);
                irq_cmd = 1'b0;
                repeat (40) @(negedge clk);
                `CHK({cpu_en, core_rst}, 2'b00)
                pin_cmd = 1'b1;
                wait_sig(1'b1, 1'b1, n);
                pin_cmd = 1'b0;
            end else begin
                wait_sig(1'b1, 1'b1, n);
                `CHK(n inside {[18:24]}, 1'b1)
            end
            `CHK({vec, osc_en}, 17'h1)
            wait_sig(1'b1, 1'b0, n);
            `CHK(cpu_en, 1'b1)
        end
        end_of_test();
    end
endmodule : core_power_mode_control_tb

`default_nettype wire
